// >>> core/nhs_device.sv
// device end: serial slave, frame check, power state and interrupt line
// assumes the host keeps its side of the handshake; link pins are asynchronous
// Operation
// RL1: target init sleeps unless field present
// RL2: target activation raises interrupt line
// RL3: host may wake device by request
// RL4: host waits ready before command
// RL5: write operation releases interrupt line
// RL6: acknowledge target init, then sleep
// RL7: held response asserts interrupt line
// RL8: read operation releases interrupt line
// RL9: virtual card and reset start asleep
// RL10: secure module event pulses line low
// RL11: general status command releases line
// RL12: virtual card excludes sleep command
// RL13: request line wakes virtual card device
// RL14: host waits 1 ms before commands
// RL15: host frame layout with D4
// RL16: response uses D5 and code plus one
// RL17: checksums sum to zero modulo 256
// RL18: without request, hold select long
`timescale 1ns/1ns
module nhs_device
   import nhs_pkg::*;
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_b_i,
   // link
   nhs_link_if.dev link,
   // chip side events
   input wire logic rf_field_i,
   input wire logic target_activated_i,
   input wire logic secure_event_i,
   // status
   output logic asleep_o,
   output logic vcard_o,
   output logic [7:0] last_cmd_o
);
   // =====================================================
   // pin synchronisers
   logic [1:0] sel_s, sck_s, mosi_s, req_s;
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         sel_s <= 2'h3;
         sck_s <= 2'h0;
         mosi_s <= 2'h0;
         req_s <= 2'h0;
      end else begin
         sel_s <= {sel_s[0], link.sel_b};
         sck_s <= {sck_s[0], link.sck};
         mosi_s <= {mosi_s[0], link.mosi};
         req_s <= {req_s[0], link.host_req};
      end
   end
   logic sck_d1_q, sel_d1_q;
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         sck_d1_q <= 1'b0;
         sel_d1_q <= 1'b1;
      end else begin
         sck_d1_q <= sck_s[1];
         sel_d1_q <= sel_s[1];
      end
   end
   wire sck_rise = sck_s[1] & ~sck_d1_q;
   wire sck_fall = ~sck_s[1] & sck_d1_q;
   wire sel_fall = ~sel_s[1] & sel_d1_q;
   wire sel_active = ~sel_s[1];
   // =====================================================
   // byte shifter, mode 0, msb first
   logic [7:0] rx_sh_q, tx_sh_q;
   logic [2:0] bit_q;
   logic byte_done_q;
   logic first_q;
   logic [7:0] opcode_q;
   logic [7:0] tx_byte;
   logic [4:0] tx_idx_q;
   always_ff @(posedge clk_i) begin
      if (!rst_b_i || !sel_active) begin
         bit_q <= 3'h0;
         byte_done_q <= 1'b0;
      end else begin
         byte_done_q <= 1'b0;
         if (sck_rise) begin
            rx_sh_q <= {rx_sh_q[6:0], mosi_s[1]};
            bit_q <= bit_q + 3'h1;
            if (bit_q == 3'h7) begin
               byte_done_q <= 1'b1;
            end
         end
      end
   end
   wire [7:0] rx_byte = rx_sh_q;
   // first byte of a select window: 01 write, 03 read (no other opcode is decoded)
   always_ff @(posedge clk_i) begin
      if (!rst_b_i || !sel_active) begin
         first_q <= 1'b1;
         opcode_q <= 8'h00;
      end else if (byte_done_q && first_q) begin
         first_q <= 1'b0;
         opcode_q <= rx_byte;
      end
   end
   wire op_write = byte_done_q && first_q && rx_byte == 8'h01;
   wire op_read = byte_done_q && first_q && rx_byte == 8'h03;
   // =====================================================
   // host frame parser
   typedef enum {P_PRE, P_START, P_LEN, P_LCS, P_DIR, P_CMD, P_DATA, P_DCS, P_POST}
      nhs_pstate_t;
   nhs_pstate_t ps_q;
   logic [7:0] len_q, cnt_q, sum_q, cmd_q, d0_q, d1_q;
   logic frame_ok_q;
   always_ff @(posedge clk_i) begin
      frame_ok_q <= 1'b0;
      if (!rst_b_i || !sel_active) begin
         ps_q <= P_PRE;
      end else if (byte_done_q && !first_q && opcode_q == 8'h01) begin
         case (ps_q)
            P_PRE: if (rx_byte == NHS_START) ps_q <= P_LEN;
            P_START: ps_q <= P_LEN;
            P_LEN: begin
               len_q <= rx_byte;
               ps_q <= P_LCS;
            end
            P_LCS: ps_q <= (8'(len_q + rx_byte) == 8'h00) ? P_DIR : P_PRE; // RL17
            P_DIR: begin
               sum_q <= rx_byte;
               cnt_q <= 8'h01;
               ps_q <= (rx_byte == NHS_DIR_H2D) ? P_CMD : P_PRE; // RL15
            end
            P_CMD: begin
               cmd_q <= rx_byte;
               sum_q <= 8'(sum_q + rx_byte);
               cnt_q <= 8'h02;
               ps_q <= (len_q == 8'h02) ? P_DCS : P_DATA;
            end
            P_DATA: begin
               if (cnt_q == 8'h02) d0_q <= rx_byte;
               if (cnt_q == 8'h03) d1_q <= rx_byte;
               sum_q <= 8'(sum_q + rx_byte);
               cnt_q <= 8'(cnt_q + 8'h01);
               if (8'(cnt_q + 8'h01) == len_q) ps_q <= P_DCS;
            end
            P_DCS: begin
               frame_ok_q <= (8'(sum_q + rx_byte) == 8'h00); // RL17
               ps_q <= P_POST;
            end
            default: ps_q <= P_PRE;
         endcase
      end
   end
   // =====================================================
   // command state and power state
   typedef enum {D_SLEEP, D_IDLE, D_ACK, D_BUSY, D_RESP, D_TGWAIT, D_PDWAIT}
      nhs_dstate_t;
   nhs_dstate_t ds_q;
   logic [15:0] pd_cnt_q;
   logic resp_tg_q;
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         ds_q <= D_SLEEP; // RL9
         vcard_o <= 1'b0;
         last_cmd_o <= 8'h00;
         resp_tg_q <= 1'b0;
         pd_cnt_q <= 16'h0000;
      end else begin
         case (ds_q)
            D_SLEEP: if (req_s[1] || sel_fall) ds_q <= D_IDLE; // RL13
            D_IDLE: if (frame_ok_q) begin
               last_cmd_o <= cmd_q;
               ds_q <= D_ACK;
            end
            D_ACK: if (op_read || ps_q == P_POST) ds_q <= D_BUSY;
            D_BUSY: begin
               if (cmd_q == NHS_SECURE_MODULE_CONFIG_CMD) vcard_o <= (d0_q == NHS_VCARD_MODE);
               if (cmd_q == NHS_TARGET_INIT_CMD) begin
                  ds_q <= rf_field_i ? D_TGWAIT : D_PDWAIT; // RL1 RL6
                  pd_cnt_q <= 16'h0000;
               end else ds_q <= D_RESP;
            end
            D_PDWAIT: begin
               pd_cnt_q <= pd_cnt_q + 16'h0001;
               // activation during power-down entry still answers at once
               if (target_activated_i) ds_q <= D_RESP; // RL2
               else if (rf_field_i || frame_ok_q) ds_q <= D_TGWAIT;
               else if (32'(pd_cnt_q) == NHS_PD_ENTRY_CYC) ds_q <= D_TGWAIT;
            end
            D_TGWAIT: if (target_activated_i) ds_q <= D_RESP; // RL2
            D_RESP: if (sel_active && opcode_q == 8'h03 && tx_idx_q > 5'd9)
               ds_q <= vcard_o ? D_SLEEP : D_IDLE; // RL9
            default: ds_q <= D_IDLE;
         endcase
         // sleep command is refused while a virtual card is configured
         if (ds_q == D_BUSY && cmd_q == NHS_SLEEP_CMD && !vcard_o) ds_q <= D_PDWAIT; // RL12
      end
   end
   assign asleep_o = (ds_q == D_SLEEP) || (ds_q == D_PDWAIT && !rf_field_i);
   // =====================================================
   // interrupt line (active low)
   logic irq_q, vpulse_q;
   logic [7:0] vpulse_cnt_q;
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         irq_q <= 1'b0;
      end else if (op_write) begin
         irq_q <= 1'b0; // RL5
      end else if (op_read && ds_q != D_ACK) begin
         irq_q <= 1'b0; // RL8
      end else if ((ds_q == D_SLEEP || ds_q == D_IDLE) && req_s[1]) begin
         irq_q <= 1'b1; // RL4
      end else if (ds_q == D_BUSY && cmd_q != NHS_TARGET_INIT_CMD) begin
         irq_q <= 1'b1; // RL7
      end else if ((ds_q == D_TGWAIT || ds_q == D_PDWAIT) && target_activated_i) begin
         irq_q <= 1'b1; // RL2
      end
   end
   // unsolicited pulse in virtual card mode, held until general status
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         vpulse_q <= 1'b0;
         vpulse_cnt_q <= 8'h00;
      end else if (vcard_o && secure_event_i) begin
         vpulse_q <= 1'b1; // RL10
      end else if (frame_ok_q && cmd_q == NHS_GENERAL_STATUS_CMD) begin
         vpulse_q <= 1'b0; // RL11
      end
   end
   assign link.host_irq_line_b = ~(irq_q | vpulse_q);
   // =====================================================
   // response transmitter: ack frame, then response frame
   wire [7:0] rcode = 8'(cmd_q + 8'h01);
   wire [7:0] rsum = 8'(8'h00 - NHS_DIR_D2H - rcode);
   always_comb begin
      tx_byte = 8'h00;
      if (ds_q == D_ACK || ds_q == D_BUSY) begin
         case (tx_idx_q)
            5'd2: tx_byte = NHS_START; // RL6
            5'd3: tx_byte = 8'h00;
            5'd4: tx_byte = 8'hFF;
            default: tx_byte = 8'h00;
         endcase
      end else begin
         case (tx_idx_q)
            5'd2: tx_byte = NHS_START;
            5'd3: tx_byte = 8'h02;
            5'd4: tx_byte = 8'hFE;
            5'd5: tx_byte = NHS_DIR_D2H; // RL16
            5'd6: tx_byte = rcode; // RL16
            5'd7: tx_byte = rsum; // RL17
            default: tx_byte = NHS_POST;
         endcase
      end
   end
   always_ff @(posedge clk_i) begin
      if (!rst_b_i || !sel_active) begin
         tx_idx_q <= 5'd0;
         tx_sh_q <= 8'h00;
      end else if (byte_done_q) begin
         tx_idx_q <= (tx_idx_q == 5'd31) ? tx_idx_q : tx_idx_q + 5'd1;
         tx_sh_q <= tx_byte;
      end else if (sck_fall && bit_q != 3'h0) begin
         tx_sh_q <= {tx_sh_q[6:0], 1'b0};
      end
   end
   assign link.miso = tx_sh_q[7];
endmodule

// >>> core/nhs_host.sv
// host end: wakes the device, sends one command frame, collects the response
// assumes the device keeps its handshake; irq line is asynchronous
`timescale 1ns/1ns
module nhs_host
   import nhs_pkg::*;
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_b_i,
   // link
   nhs_link_if.host link,
   // user request
   input wire logic start_i,
   input wire logic use_req_i,
   input wire logic [7:0] cmd_i,
   input wire logic [7:0] arg_i,
   // user answer
   output logic busy_o,
   output logic done_o,
   output logic [7:0] resp_code_o
);
   // =====================================================
   // irq synchroniser
   logic [1:0] irq_s;
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) irq_s <= 2'h3;
      else irq_s <= {irq_s[0], link.host_irq_line_b};
   end
   wire ready = ~irq_s[1];
   // =====================================================
   // sequencer
   typedef enum {H_IDLE, H_WAKE, H_SEL, H_XFER, H_GAP, H_WAITIRQ, H_QUIET} nhs_hstate_t;
   nhs_hstate_t hs_q;
   logic [4:0] idx_q, nbytes_q;
   logic [2:0] bit_q;
   logic [2:0] half_q;
   logic rd_q;
   logic [7:0] sh_q, rx_q;
   logic [15:0] wait_q;
   logic [7:0] len;
   logic [7:0] byte_out;
   logic [4:0] bidx;
   assign len = 8'h03;
   // index of the byte to load next: first byte on select, else the following one
   assign bidx = (hs_q == H_XFER) ? idx_q + 5'd1 : 5'd0;
   always_comb begin
      case (bidx)
         5'd0: byte_out = 8'h01;
         5'd1: byte_out = NHS_PRE;
         5'd2: byte_out = NHS_PRE;
         5'd3: byte_out = NHS_START;
         5'd4: byte_out = len;
         5'd5: byte_out = 8'(8'h00 - len); // RL17
         5'd6: byte_out = NHS_DIR_H2D; // RL15
         5'd7: byte_out = cmd_i;
         5'd8: byte_out = arg_i;
         5'd9: byte_out = 8'(8'h00 - NHS_DIR_H2D - cmd_i - arg_i); // RL17
         default: byte_out = NHS_POST;
      endcase
      if (rd_q && bidx == 5'd0) byte_out = 8'h03;
      else if (rd_q) byte_out = 8'h00;
   end
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         hs_q <= H_IDLE;
         link.sel_b <= 1'b1;
         link.sck <= 1'b0;
         link.mosi <= 1'b0;
         link.host_req <= 1'b0;
         idx_q <= 5'd0;
         bit_q <= 3'h0;
         half_q <= 3'h0;
         rd_q <= 1'b0;
         nbytes_q <= 5'd0;
         sh_q <= 8'h00;
         rx_q <= 8'h00;
         wait_q <= 16'h0000;
         done_o <= 1'b0;
         resp_code_o <= 8'h00;
      end else begin
         done_o <= 1'b0;
         case (hs_q)
            H_IDLE: if (start_i) begin
               rd_q <= 1'b0;
               nbytes_q <= 5'd11;
               wait_q <= 16'h0000;
               link.host_req <= use_req_i; // RL3
               hs_q <= use_req_i ? H_WAKE : H_SEL;
            end
            H_WAKE: if (ready) begin // RL4
               hs_q <= H_SEL;
            end
            H_SEL: begin
               link.sel_b <= 1'b0;
               wait_q <= wait_q + 16'h0001;
               // select held long to wake a sleeping device
               if (link.host_req || rd_q || wait_q == 16'd200) begin // RL18
                  link.host_req <= 1'b0;
                  idx_q <= 5'd0;
                  bit_q <= 3'h0;
                  sh_q <= byte_out;
                  link.mosi <= byte_out[7];
                  hs_q <= H_XFER;
               end
            end
            H_XFER: begin
               half_q <= half_q + 3'h1;
               if (32'(half_q) == NHS_SCK_HALF_CYC - 1) begin
                  half_q <= 3'h0;
                  link.sck <= ~link.sck;
                  if (!link.sck) begin
                     rx_q <= {rx_q[6:0], link.miso};
                  end else if (bit_q == 3'h7) begin
                     bit_q <= 3'h0;
                     if (rd_q && idx_q == 5'd7) resp_code_o <= rx_q;
                     if (idx_q + 5'd1 == nbytes_q) begin
                        hs_q <= H_GAP;
                     end else begin
                        // next byte leads with its msb before the next rise
                        idx_q <= idx_q + 5'd1;
                        sh_q <= byte_out;
                        link.mosi <= byte_out[7];
                        hs_q <= H_XFER;
                     end
                  end else begin
                     bit_q <= bit_q + 3'h1;
                     sh_q <= {sh_q[6:0], 1'b0};
                     link.mosi <= sh_q[6];
                  end
               end
            end
            H_GAP: begin
               link.sel_b <= 1'b1;
               hs_q <= rd_q ? H_QUIET : H_WAITIRQ;
               wait_q <= 16'h0000;
            end
            H_WAITIRQ: if (ready) begin // RL7
               rd_q <= 1'b1;
               nbytes_q <= 5'd10;
               hs_q <= H_SEL;
            end
            H_QUIET: begin
               wait_q <= wait_q + 16'h0001;
               if (32'(wait_q) == NHS_PD_ENTRY_CYC) begin // RL14
                  done_o <= 1'b1;
                  hs_q <= H_IDLE;
               end
            end
            default: hs_q <= H_IDLE;
         endcase
      end
   end
   assign busy_o = (hs_q != H_IDLE);
endmodule

// >>> core/nhs_link_if.sv
// interface carrying the serial link, interrupt line and request line
// assumes both ends run on the same core clock; pins are plain push-pull
`timescale 1ns/1ns
interface nhs_link_if;
   logic sel_b;
   logic sck;
   logic mosi;
   logic miso;
   logic host_irq_line_b;
   logic host_req;
   modport dev (input sel_b, input sck, input mosi, input host_req,
      output miso, output host_irq_line_b);
   modport host (output sel_b, output sck, output mosi, output host_req,
      input miso, input host_irq_line_b);
endinterface

// >>> core/nhs_pkg.sv
// package for the host serial handshake pair: frame bytes, command codes, timing
// assumes a 20 MHz core clock on both ends
package nhs_pkg;
   // =====================================================
   // frame bytes
   localparam logic [7:0] NHS_PRE = 8'h00;
   localparam logic [7:0] NHS_START = 8'hFF;
   localparam logic [7:0] NHS_DIR_H2D = 8'hD4;
   localparam logic [7:0] NHS_DIR_D2H = 8'hD5;
   localparam logic [7:0] NHS_POST = 8'h00;
   // =====================================================
   // command codes
   localparam logic [7:0] NHS_GENERAL_STATUS_CMD = 8'h04;
   localparam logic [7:0] NHS_SECURE_MODULE_CONFIG_CMD = 8'h14;
   localparam logic [7:0] NHS_SLEEP_CMD = 8'h16;
   localparam logic [7:0] NHS_TARGET_INIT_CMD = 8'h8C;
   localparam logic [7:0] NHS_VCARD_MODE = 8'h02;
   // =====================================================
   // timing
   localparam int NHS_CLK_HZ = 20_000_000;
   localparam int NHS_PD_ENTRY_US = 1000;
   localparam int NHS_PD_ENTRY_CYC = NHS_PD_ENTRY_US * (NHS_CLK_HZ / 1_000_000);
   localparam int NHS_SCK_HALF_CYC = 4;
   localparam int NHS_IRQ_PULSE_CYC = 20;
   localparam int NHS_MAX_DATA = 16;
   localparam int NHS_RESET_DOWN = 1;
endpackage

// >>> test/nhs_link_sva.sv
// checker for the serial link between the host end and the device end
// assumes its inputs are the link interface signals, wired by name
`timescale 1ns/1ns
module nhs_link_sva
   import nhs_pkg::*;
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_b_i,
   // link signals
   input wire logic sel_b,
   input wire logic sck,
   input wire logic mosi,
   input wire logic miso,
   input wire logic host_irq_line_b,
   input wire logic host_req
);
   // ==========
   // first byte capture
   localparam int QUIET_MIN = NHS_PD_ENTRY_CYC - 16;
   logic sck_q;
   logic [3:0] nbit_q;
   logic [7:0] op_q;
   logic rd_last_q;
   logic [15:0] gap_q;
   logic op_end;
   logic [7:0] op_now;
   logic irq_line_q;
   logic unsol_q;
   // eighth rising clock of a frame ends the opcode
   assign op_end = !sel_b && sck && !sck_q && nbit_q == 4'h7;
   assign op_now = {op_q[6:0], mosi};
   // clock history for edge finding
   always_ff @(posedge clk_i) begin
      sck_q <= sck;
   end
   // opcode shifter, cleared while deselected
   always_ff @(posedge clk_i) begin
      if (!rst_b_i || sel_b) begin
         nbit_q <= 4'h0;
         op_q <= 8'h00;
      end else if (sck && !sck_q && nbit_q < 4'h8) begin
         nbit_q <= nbit_q + 4'h1;
         op_q <= op_now;
      end
   end
   // remembers whether the last frame was a read
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         rd_last_q <= 1'b0;
      end else if (op_end) begin
         rd_last_q <= (op_now == 8'h03);
      end
   end
   // line fall after a read, deselected and unrequested, is an unsolicited event
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         irq_line_q <= 1'b1;
         unsol_q <= 1'b0;
      end else begin
         irq_line_q <= host_irq_line_b;
         if (host_irq_line_b) unsol_q <= 1'b0;
         else if (irq_line_q && sel_b && !host_req && rd_last_q) unsol_q <= 1'b1;
      end
   end
   // cycles spent deselected, saturating
   always_ff @(posedge clk_i) begin
      if (!rst_b_i || !sel_b) begin
         gap_q <= 16'h0000;
      end else if (gap_q != 16'hFFFF) begin
         gap_q <= gap_q + 16'h0001;
      end
   end
   // ==========
   // properties
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);
   a_reset_idle_lines: assert property (
      $rose(rst_b_i) |-> host_irq_line_b && sel_b && !sck && !host_req)
      else $error("lines not idle after reset");
   a_sck_idle_low: assert property (sel_b |-> !sck)
      else $error("link clock moves while deselected");
   a_req_wakes_irq: assert property (
      $rose(host_req) |-> ##[1:200] !host_irq_line_b)
      else $error("request not answered on interrupt line");
   a_req_waits_ready: assert property (
      $fell(sel_b) && $past(host_req) |-> !host_irq_line_b)
      else $error("select before device ready");
   a_write_release: assert property (
      op_end && op_now == 8'h01 && !unsol_q |-> ##[1:12] host_irq_line_b)
      else $error("line not released after write opcode");
   a_read_release: assert property (
      op_end && op_now == 8'h03 && !host_irq_line_b |-> ##[1:12] host_irq_line_b)
      else $error("line not released after read opcode");
   a_select_hold: assert property (
      $fell(sel_b) && !host_req && host_irq_line_b |-> !sck [*8])
      else $error("clock started too soon after select");
   a_quiet_after_read: assert property (
      $fell(sel_b) && rd_last_q |-> gap_q >= QUIET_MIN)
      else $error("command sent during power down entry");
endmodule

// >>> test/tb_top.sv
// self-checking bench for the host and device ends of the serial link
// assumes package, interface and both ends compile first
`timescale 1ns/1ns
module tb_top import nhs_pkg::*;;
   // ==========
   // signals
   logic clk_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic rf_field_i = 1'b0;
   logic target_activated_i = 1'b0;
   logic secure_event_i = 1'b0;
   logic start_i = 1'b0;
   logic use_req_i = 1'b0;
   logic [7:0] cmd_i = 8'h00;
   logic [7:0] arg_i = 8'h00;
   logic asleep_o;
   logic vcard_o;
   logic [7:0] last_cmd_o;
   logic busy_o;
   logic done_o;
   logic [7:0] resp_code_o;
   int failures = 0;
   int num_checks = 0;
   int n_done = 0;
   int n0_g = 0;
   logic [31:0] rnd_q = 32'h0000_DA92;
   logic [15:0] exp_q[$];
   // good data checksum would be 28
   logic [7:0] flt_bytes [11] = '{8'h01, 8'h00, 8'h00, 8'hFF, 8'h03, 8'hFD, 8'hD4,
      8'h04, 8'h00, 8'h29, 8'h00};
   // clock
   always #25 clk_i = ~clk_i;
   // ==========
   // both ends, checker, and a second device for broken frames
   nhs_link_if nhs_link_if_i();
   nhs_link_if flt_if_i();
   nhs_device nhs_device_i (.clk_i, .rst_b_i, .link(nhs_link_if_i), .rf_field_i,
      .target_activated_i, .secure_event_i, .asleep_o, .vcard_o, .last_cmd_o);
   nhs_host nhs_host_i (.clk_i, .rst_b_i, .link(nhs_link_if_i), .start_i, .use_req_i,
      .cmd_i, .arg_i, .busy_o, .done_o, .resp_code_o);
   nhs_link_sva nhs_link_sva_i (.clk_i, .rst_b_i, .sel_b(nhs_link_if_i.sel_b),
      .sck(nhs_link_if_i.sck), .mosi(nhs_link_if_i.mosi), .miso(nhs_link_if_i.miso),
      .host_irq_line_b(nhs_link_if_i.host_irq_line_b), .host_req(nhs_link_if_i.host_req));
   nhs_device nhs_device_flt_i (.clk_i, .rst_b_i, .link(flt_if_i), .rf_field_i(1'b0),
      .target_activated_i(1'b0), .secure_event_i(1'b0), .asleep_o(), .vcard_o(),
      .last_cmd_o());
   // ==========
   // helpers
   function automatic logic [31:0] xs(input logic [31:0] x);
      logic [31:0] y;
      y = x ^ (x << 13);
      y = y ^ (y >> 17);
      return y ^ (y << 5);
   endfunction
   task automatic test_done;
      if (failures == 0 && num_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic bad(input string msg);
      failures++;
      $display("BAD %0t %s", $time, msg);
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
      num_checks++;
      if (got !== exp) bad(msg);
   endtask
   task automatic wait_lvl(ref logic s, input logic lvl, input int lim);
      int n;
      n = 0;
      while (s !== lvl && n < lim) begin
         @(negedge clk_i);
         n++;
      end
      if (s !== lvl) begin
         bad("wait ran out");
         test_done();
      end
   endtask
   // starts one exchange and notes the expected answer
   task automatic send(input logic [7:0] cmd, input logic [7:0] arg, input logic req);
      wait_lvl(busy_o, 1'b0, 100);
      n0_g = n_done;
      exp_q.push_back({cmd, cmd + 8'h01});
      @(posedge clk_i);
      cmd_i <= cmd;
      arg_i <= arg;
      use_req_i <= req;
      start_i <= 1'b1;
      @(posedge clk_i);
      start_i <= 1'b0;
   endtask
   task automatic finish;
      int n;
      n = 0;
      while (n_done == n0_g && n < 60000) begin
         @(negedge clk_i);
         n++;
      end
      if (n_done == n0_g) begin
         bad("no answer");
         test_done();
      end
   endtask
   task automatic flt_byte(input logic [7:0] b);
      for (int i = 7; i >= 0; i--) begin
         flt_if_i.mosi <= b[i];
         repeat (4) @(posedge clk_i);
         flt_if_i.sck <= 1'b1;
         repeat (4) @(posedge clk_i);
         flt_if_i.sck <= 1'b0;
      end
   endtask
   // compare each finished exchange with the oldest note
   always @(negedge clk_i) begin
      if (done_o === 1'b1) begin
         n_done++;
         if (exp_q.size() == 0) bad("answer without request");
         else chk({last_cmd_o, resp_code_o}, exp_q.pop_front(), "answer code");
      end
   end
   // ==========
   // main sequence
   initial begin
      flt_if_i.sel_b = 1'b1;
      flt_if_i.sck = 1'b0;
      flt_if_i.mosi = 1'b0;
      flt_if_i.host_req = 1'b0;
      repeat (5) @(posedge clk_i);
      rst_b_i <= 1'b1;
      @(negedge clk_i);
      chk(16'(asleep_o), 16'h0001, "awake after reset");
      // broken checksum on the second pair gets no answer
      @(posedge clk_i);
      flt_if_i.host_req <= 1'b1;
      wait_lvl(flt_if_i.host_irq_line_b, 1'b0, 400);
      @(posedge clk_i);
      flt_if_i.sel_b <= 1'b0;
      flt_if_i.host_req <= 1'b0;
      foreach (flt_bytes[k]) flt_byte(flt_bytes[k]);
      flt_if_i.sel_b <= 1'b1;
      repeat (2000) @(posedge clk_i);
      chk(16'(flt_if_i.host_irq_line_b), 16'h0001, "bad frame answered");
      // status with wake request, random argument
      rnd_q = xs(rnd_q);
      send(NHS_GENERAL_STATUS_CMD, rnd_q[7:0], 1'b1);
      finish();
      // target init: wake by select, ack, sleep, activation raises line
      send(NHS_TARGET_INIT_CMD, 8'h00, 1'b0);
      wait_lvl(asleep_o, 1'b0, 2000);
      wait_lvl(asleep_o, 1'b1, 25000);
      chk(16'(nhs_link_if_i.host_irq_line_b), 16'h0001, "line low while idle");
      rnd_q = xs(rnd_q);
      repeat (rnd_q[7:0]) @(posedge clk_i);
      target_activated_i <= 1'b1;
      wait_lvl(nhs_link_if_i.host_irq_line_b, 1'b0, 400);
      finish();
      @(posedge clk_i);
      target_activated_i <= 1'b0;
      // virtual card mode, device sleeps waiting for events
      send(NHS_SECURE_MODULE_CONFIG_CMD, NHS_VCARD_MODE, 1'b1);
      finish();
      wait_lvl(asleep_o, 1'b1, 400);
      chk(16'(vcard_o), 16'h0001, "not in virtual card mode");
      // event pulse outside any exchange, cleared by status
      @(posedge clk_i);
      secure_event_i <= 1'b1;
      wait_lvl(nhs_link_if_i.host_irq_line_b, 1'b0, 200);
      chk(16'(nhs_link_if_i.sel_b), 16'h0001, "pulse inside exchange");
      @(posedge clk_i);
      secure_event_i <= 1'b0;
      rnd_q = xs(rnd_q);
      send(NHS_GENERAL_STATUS_CMD, rnd_q[7:0], 1'b1);
      finish();
      chk(16'(nhs_link_if_i.host_irq_line_b), 16'h0001, "line held after status");
      test_done();
   end
endmodule
